// ---- inc/esr_consts.svh ----
// register offsets, field positions and reset values of the serial receiver
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
`ifndef ESR_CONSTS_SVH
`define ESR_CONSTS_SVH

// ------------------------------------------------
// register byte offsets
// ------------------------------------------------
`define ESR_A_CTRL 8'h00
`define ESR_A_STAT 8'h04
`define ESR_A_DATA 8'h08
`define ESR_A_BAUD 8'h0c
`define ESR_A_IRQ_STAT 8'h10
`define ESR_A_IRQ_MASK 8'h14

// ------------------------------------------------
// control register fields
// ------------------------------------------------
`define ESR_B_SERIAL_PORT_ENABLE 0
`define ESR_B_SYNC_MODE_SELECT 1
`define ESR_B_MASTER_CLOCK_SOURCE_SELECT 2
`define ESR_B_SINGLE_RECEIVE_ENABLE 3
`define ESR_B_CONTINUOUS_RECEIVE_ENABLE 4
`define ESR_B_NINE_BIT_RECEIVE_ENABLE 5
`define ESR_B_SIXTEEN_BIT_DIVISOR_SELECT 6
`define ESR_CTRL_W 7
`define ESR_CTRL_RESET 7'h00

// ------------------------------------------------
// status, interrupt and divisor fields
// ------------------------------------------------
`define ESR_B_NINTH_RECEIVED_BIT 0
`define ESR_B_OVERRUN_ERROR_FLAG 1
`define ESR_B_RECEIVE_INTERRUPT_FLAG 2
`define ESR_B_EV_CHAR 0
`define ESR_B_EV_OVERRUN 1
`define ESR_IRQ_W 2
`define ESR_IRQ_RESET 2'h0
`define ESR_BAUD_RESET 16'h0000
`define ESR_DEPTH 2
`define ESR_LAST_BIT8 4'h7
`define ESR_LAST_BIT9 4'h8

`endif

// ---- inc/esr_pkg.sv ----
// types shared by the serial receiver files
// assumes esr_consts.svh supplies all numbers
package esr_pkg;

  // receive sequencer states
  typedef enum logic [0:0] {ESR_IDLE, ESR_SHIFT} esr_state_e;

  // one received character, ninth bit on top
  typedef logic [8:0] esr_char_t;

endpackage

// ---- rtl/esr_baud_gen.sv ----
// half-period tick generator for the generated serial clock
// assumes run is synchronous to clk and divisors are static while running
`timescale 1ns/1ns
`include "esr_consts.svh"

module esr_baud_gen (
  input wire logic clk, // system clock
  input wire logic reset, // async reset, active high
  input wire logic run, // count while high
  input wire logic sixteen_bit, // use high and low divisor bytes
  input wire logic [15:0] divisor, // baud_divisor_high:baud_divisor_low
  output logic tick // one-cycle pulse per half period
);

  // ------------------------------------------------
  // divider
  // ------------------------------------------------
  logic [15:0] cnt_r; // cycles since last tick
  logic [15:0] limit; // terminal count

  // eight-bit mode ignores the high byte
  assign limit = sixteen_bit ? divisor : {8'h00, divisor[7:0]};

  // counter restarts from zero so the first half period is whole
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end
    else if (cnt_r >= limit)
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule

// ---- rtl/esr_receiver.sv ----
// synchronous receive path with a two-character queue and overrun handling
// assumes an apb master on clk; serial pins are asynchronous to clk
`timescale 1ns/1ns
`include "esr_consts.svh"

module esr_receiver (
  input wire logic clk, // system clock, 10 MHz
  input wire logic reset, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic rx_data_pin, // serial data line
  input wire logic clk_pin_i, // serial clock pin level
  output logic clk_pin_o, // serial clock driven level
  output logic clk_pin_oe_n, // low while driving clock pin
  output logic irq // level interrupt
);

  // ------------------------------------------------
  // declarations
  // ------------------------------------------------
  logic [`ESR_CTRL_W-1:0] ctrl_r; // control bits
  logic [15:0] baud_r; // divisor pair
  logic [`ESR_IRQ_W-1:0] ist_r; // sticky events
  logic [`ESR_IRQ_W-1:0] imask_r; // event enables
  logic [31:0] prdata_r; // read data latched at setup
  logic rd_ok_r; // queue non-empty at setup
  esr_pkg::esr_char_t mem_r [0:`ESR_DEPTH-1]; // queue storage
  logic wr_ptr_r; // next write slot
  logic rd_ptr_r; // oldest slot
  logic [1:0] cnt_r; // characters queued
  logic ovr_r; // overrun_error_flag
  logic ovr_cont_r; // overrun arose in continuous mode
  esr_pkg::esr_state_e state_r; // sequencer state
  logic [3:0] bit_cnt_r; // bits taken this character
  logic [8:0] sh_r; // receive_shift_register
  logic ck_r; // generated clock level
  logic dat_s1, dat_s2; // data synchroniser
  logic ck_s1, ck_s2, ck_s3; // clock synchroniser and delay

  // ------------------------------------------------
  // control fields
  // ------------------------------------------------
  wire serial_port_enable = ctrl_r[`ESR_B_SERIAL_PORT_ENABLE];
  wire sync_mode_select = ctrl_r[`ESR_B_SYNC_MODE_SELECT];
  wire master_clock_source_select = ctrl_r[`ESR_B_MASTER_CLOCK_SOURCE_SELECT];
  wire single_receive_enable = ctrl_r[`ESR_B_SINGLE_RECEIVE_ENABLE];
  wire continuous_receive_enable = ctrl_r[`ESR_B_CONTINUOUS_RECEIVE_ENABLE];
  wire nine_bit_receive_enable = ctrl_r[`ESR_B_NINE_BIT_RECEIVE_ENABLE];
  wire sixteen_bit_divisor_select = ctrl_r[`ESR_B_SIXTEEN_BIT_DIVISOR_SELECT];

  // ------------------------------------------------
  // apb decode
  // ------------------------------------------------
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire sel_ctrl = paddr == `ESR_A_CTRL;
  wire sel_stat = paddr == `ESR_A_STAT;
  wire sel_data = paddr == `ESR_A_DATA;
  wire sel_baud = paddr == `ESR_A_BAUD;
  wire sel_ist = paddr == `ESR_A_IRQ_STAT;
  wire sel_imask = paddr == `ESR_A_IRQ_MASK;
  wire hit = sel_ctrl | sel_stat | sel_data | sel_baud | sel_ist | sel_imask;
  wire wr = access && pwrite && hit;
  wire data_rd = access && !pwrite && sel_data;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign prdata = prdata_r;

  // ------------------------------------------------
  // receive control
  // ------------------------------------------------
  wire port_on = serial_port_enable && sync_mode_select;
  wire master = port_on && master_clock_source_select;
  wire rx_go = port_on && (single_receive_enable || continuous_receive_enable) && !ovr_r;
  wire shifting = state_r == esr_pkg::ESR_SHIFT;
  wire tick; // half-period pulse from the divider
  wire ck_fall = ck_s3 && !ck_s2; // external clock falling edge
  wire samp = shifting && rx_go && (master ? (tick && ck_r) : ck_fall);
  wire [3:0] last_bit = nine_bit_receive_enable ? `ESR_LAST_BIT9 : `ESR_LAST_BIT8;
  wire done = samp && bit_cnt_r == last_bit;
  wire [8:0] sh_nxt = {dat_s2, sh_r[8:1]}; // lsb first
  wire [8:0] char_nxt = nine_bit_receive_enable ? sh_nxt : {1'b0, sh_nxt[8:1]};

  // ------------------------------------------------
  // queue control
  // ------------------------------------------------
  wire full = cnt_r == 2'(`ESR_DEPTH);
  wire push = done && !full;
  wire ovr_set = done && full;
  wire pop = data_rd && rd_ok_r && cnt_r != 2'h0;
  wire rx_flag = cnt_r != 2'h0;
  wire head_ninth = mem_r[rd_ptr_r][8];
  wire [1:0] cnt_nxt = cnt_r + 2'(push) - 2'(pop);

  // overrun clear depends on the mode it arose in
  wire ovr_clr = !serial_port_enable ||
    (ovr_cont_r ? !continuous_receive_enable : data_rd);
  wire [`ESR_IRQ_W-1:0] ev = {ovr_set, push};

  // ------------------------------------------------
  // read mux
  // ------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl)
      rd_mux = 32'(ctrl_r);
    else if (sel_stat)
      rd_mux = {29'h0, rx_flag, ovr_r, head_ninth};
    else if (sel_data)
      rd_mux = {24'h0, mem_r[rd_ptr_r][7:0]};
    else if (sel_baud)
      rd_mux = {16'h0, baud_r};
    else if (sel_ist)
      rd_mux = 32'(ist_r);
    else if (sel_imask)
      rd_mux = 32'(imask_r);
  end

  // read data is captured in setup so prdata comes from a flop
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prdata_r <= 32'h0000_0000;
      rd_ok_r <= 1'b0;
    end
    else if (setup)
    begin
      prdata_r <= rd_mux;
      rd_ok_r <= rx_flag;
    end
  end

  // ------------------------------------------------
  // software registers
  // ------------------------------------------------
  // a single reception ends itself; a write in the same cycle wins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ctrl_r <= `ESR_CTRL_RESET;
    else if (wr && sel_ctrl)
      ctrl_r <= pwdata[`ESR_CTRL_W-1:0];
    else if (done && !continuous_receive_enable)
      ctrl_r[`ESR_B_SINGLE_RECEIVE_ENABLE] <= 1'b0;
  end

  // divisor pair and interrupt mask
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      baud_r <= `ESR_BAUD_RESET;
      imask_r <= `ESR_IRQ_RESET;
    end
    else
    begin
      if (wr && sel_baud)
        baud_r <= pwdata[15:0];
      if (wr && sel_imask)
        imask_r <= pwdata[`ESR_IRQ_W-1:0];
    end
  end

  // sticky events: write one to clear, a new event wins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ist_r <= `ESR_IRQ_RESET;
    else
      ist_r <= (ist_r & ~((wr && sel_ist) ? pwdata[`ESR_IRQ_W-1:0] : `ESR_IRQ_RESET)) | ev;
  end

  // mask bit 0 acts as the receive interrupt enable
  assign irq = |(ist_r & imask_r);

  // ------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dat_s1 <= 1'b1;
      dat_s2 <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
    end
    else
    begin
      dat_s1 <= rx_data_pin;
      dat_s2 <= dat_s1;
      ck_s1 <= clk_pin_i;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
    end
  end

  // ------------------------------------------------
  // serial clock generation
  // ------------------------------------------------
  esr_baud_gen u_baud (
    .clk(clk),
    .reset(reset),
    .run(master && shifting && rx_go),
    .sixteen_bit(sixteen_bit_divisor_select),
    .divisor(baud_r),
    .tick(tick)
  );

  // clock idles low; data is taken as it falls, giving the
  // transmitter a whole high phase to settle the line
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ck_r <= 1'b0;
    else if (!(master && shifting && rx_go))
      ck_r <= 1'b0;
    else if (tick)
      ck_r <= !ck_r;
  end

  assign clk_pin_o = ck_r;
  assign clk_pin_oe_n = !master;

  // ------------------------------------------------
  // receive sequencer
  // ------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= esr_pkg::ESR_IDLE;
      bit_cnt_r <= 4'h0;
      sh_r <= 9'h000;
    end
    else
    begin
      case (state_r)
        esr_pkg::ESR_IDLE:
        begin
          bit_cnt_r <= 4'h0;
          if (rx_go)
            state_r <= esr_pkg::ESR_SHIFT;
        end
        esr_pkg::ESR_SHIFT:
        begin
          // dropping an enable abandons the partial character
          if (!rx_go)
          begin
            state_r <= esr_pkg::ESR_IDLE;
            bit_cnt_r <= 4'h0;
          end
          else if (done)
          begin
            bit_cnt_r <= 4'h0;
            sh_r <= sh_nxt;
            if (!continuous_receive_enable)
              state_r <= esr_pkg::ESR_IDLE;
          end
          else if (samp)
          begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            sh_r <= sh_nxt;
          end
        end
        default:
          state_r <= esr_pkg::ESR_IDLE;
      endcase
    end
  end

  // ------------------------------------------------
  // two-entry queue
  // ------------------------------------------------
  // the new character is only written when a slot is free
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= char_nxt;
  end

  // pointers and count; port disable empties the queue
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else if (!serial_port_enable)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= !wr_ptr_r;
      if (pop)
        rd_ptr_r <= !rd_ptr_r;
      cnt_r <= cnt_nxt;
    end
  end

  // ------------------------------------------------
  // overrun flag
  // ------------------------------------------------
  // no register write loads this flop; a control write can clear it through ovr_clr
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ovr_r <= 1'b0;
      ovr_cont_r <= 1'b0;
    end
    else if (ovr_set)
    begin
      ovr_r <= 1'b1;
      ovr_cont_r <= continuous_receive_enable;
    end
    else if (ovr_r && ovr_clr)
      ovr_r <= 1'b0;
  end

  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_full_arrival;
    done && full;
  endsequence

  sequence s_master_fall;
    master && shifting && rx_go && tick && ck_r;
  endsequence

  a_queue_bound: assert property (push |-> cnt_r < 2'(`ESR_DEPTH))
    else $error("character written into a full queue");
  a_ovr_set: assert property (s_full_arrival |=> ovr_r && cnt_r == 2'(`ESR_DEPTH))
    else $error("overrun not flagged on third character");
  a_keep_data: assert property (s_full_arrival |=> mem_r[0] == $past(mem_r[0]) && mem_r[1] == $past(mem_r[1]))
    else $error("queued data changed on overrun");
  a_no_accept: assert property (ovr_r |-> !push ##1 !shifting)
    else $error("character accepted during overrun");
  a_ovr_rdclr: assert property (ovr_r && !ovr_cont_r && data_rd && serial_port_enable |=> !ovr_r)
    else $error("single-mode overrun not cleared by data read");
  a_ovr_cont: assert property (ovr_r && ovr_cont_r && continuous_receive_enable && serial_port_enable
    |=> ovr_r)
    else $error("continuous overrun cleared by a read");
  a_port_clr: assert property (ovr_r && !serial_port_enable |=> !ovr_r && cnt_r == 2'h0)
    else $error("port disable left overrun or data");
  a_char_len: assert property (done |-> bit_cnt_r == (nine_bit_receive_enable ? 4'h8 : 4'h7))
    else $error("wrong number of bits per character");
  a_ninth_head: assert property (push && cnt_r == 2'h0 && !pop |=> head_ninth == $past(char_nxt[8]))
    else $error("ninth bit not shown for oldest character");
  a_irq_gate: assert property (push && !imask_r[1] ##1 !imask_r[0] && !ist_r[1] |-> !irq)
    else $error("interrupt without enable");
  a_irq_raise: assert property (push && imask_r[0] |=> irq && ist_r[0])
    else $error("no interrupt on completed character");
  a_clk_fall: assert property (s_master_fall |-> samp ##1 !ck_r && !clk_pin_oe_n)
    else $error("master clock not sampled on its fall");
  a_flag_drop: assert property (pop && cnt_r == 2'h1 && !push |=> !rx_flag)
    else $error("receive flag held after last read");

endmodule

// ---- testbench/esr_tx_model.sv ----
// remote serial transmitter on the receiver's data line
// assumes the receiver samples data on falling clock edges, lsb first
`timescale 1ns/1ns

module esr_tx_model (
  input wire logic clk_pin_o, // clock from the receiver
  input wire logic clk_pin_oe_n, // low while the receiver drives the clock
  output logic clk_pin_i, // clock level at the pin
  output logic rx_data_pin // data towards the receiver
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  esr_pkg::esr_char_t tx_q[$]; // characters waiting to go out
  logic nine = 1'b0; // nine bits a character
  logic slow = 1'b0; // answer late in the high phase
  logic own_clk = 1'b0; // clock made here when the receiver is slave
  int bit_idx = 0; // next bit of the head character
  int edges = 0; // rising clock edges seen

  // the pin follows whoever drives it
  assign clk_pin_i = (clk_pin_oe_n == 1'b0) ? clk_pin_o : own_clk; // one pin out and back

  // ----------------------------------------
  // shift out on rising edges so data is settled at the falling sample edge
  // ----------------------------------------
  initial rx_data_pin = 1'b1; // plain digital level, never an analog one
  always @(posedge clk_pin_i)
  begin
    edges++;
    if (slow)
      #100; // slow answer, still well clear of the falling edge
    if (tx_q.size() == 0)
      rx_data_pin <= ~rx_data_pin; // nothing to send: never repeat a stale level
    else
    begin
      rx_data_pin <= tx_q[0][bit_idx]; // lsb first, ninth bit last
      bit_idx++;
      if (bit_idx == (nine ? 9 : 8))
      begin
        bit_idx = 0;
        void'(tx_q.pop_front());
      end
    end
  end

  // one frame of slave clocking at 800 ns; the clock stands low between frames
  task automatic run_clock(input int bits);
    #37; // phase unrelated to the system clock
    repeat (bits)
    begin
      own_clk = 1'b1;
      #400;
      own_clk = 1'b0;
      #400;
    end
  endtask
endmodule

// ---- testbench/serial_receiver_overrun_sync_test.sv ----
// self-checking bench: apb host on one side, transmitter model on the serial side
// assumes zero-wait apb and small divisors so characters stay short
`timescale 1ns/1ns
`include "esr_consts.svh"

module serial_receiver_overrun_sync_test;
  typedef struct {string what; logic [31:0] val; logic [31:0] care; logic err;} esr_note_s; // one expected read
  localparam logic [31:0] skip_ninth = 32'hfffffffe; // ninth bit is meaningless in 8-bit mode
  logic clk = 1'b0; // system clock
  logic reset = 1'b1; // held for 8 cycles
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb access phase
  logic pwrite = 1'b0; // apb direction
  logic [7:0] paddr = 8'h00; // apb address
  logic [31:0] pwdata = 32'h0; // apb write data
  logic [31:0] prdata; // apb read data
  logic pready, pslverr, rx_data_pin, clk_pin_i, clk_pin_o, clk_pin_oe_n, irq; // outputs and pins
  int errors = 0; // mismatches
  int tests_run = 0; // comparisons
  esr_note_s notes[$]; // expected reads, oldest first
  esr_note_s got; // note being compared
  esr_pkg::esr_char_t c[3]; // characters sent
  time t0; // clock period measurement

  esr_receiver i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_data_pin(rx_data_pin), .clk_pin_i(clk_pin_i), .clk_pin_o(clk_pin_o),
    .clk_pin_oe_n(clk_pin_oe_n), .irq(irq));
  esr_tx_model i_tx (.clk_pin_o(clk_pin_o), .clk_pin_oe_n(clk_pin_oe_n), .clk_pin_i(clk_pin_i),
    .rx_data_pin(rx_data_pin));

  always #50 clk = ~clk;

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // apb master; one idle cycle after each transfer keeps drives single per step
  // ----------------------------------------
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  // note the expected word, then read; the monitor compares
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] v,
    input logic [31:0] care = 32'hffffffff, input logic err = 1'b0);
    notes.push_back('{what, v, care, err});
    apb(a, 1'b0, 32'h0);
  endtask

  // read results appear at the edge that samples pready
  always @(posedge clk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
    begin
      got = notes.pop_front();
      check(got.what, prdata & got.care, got.val & got.care);
      check({got.what, " slverr"}, {31'h0, pslverr}, {31'h0, got.err});
    end

  // random characters for the transmitter
  task automatic load(input int n, input logic nine);
    for (int i = 0; i < n; i++)
    begin
      c[i] = esr_pkg::esr_char_t'($urandom);
      if (!nine)
        c[i][8] = 1'b0;
      i_tx.tx_q.push_back(c[i]);
    end
  endtask

  // a character takes bits clock periods of 2*half system cycles
  task automatic wait_chars(input int n, input int bits, input int half);
    repeat (n * bits * 2 * half + 20) @(posedge clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(24543));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("oe_n", {31'h0, clk_pin_oe_n}, 32'h1);
    check("irq", {31'h0, irq}, 32'h0);
    rd("ctrl", `ESR_A_CTRL, 32'h0);
    check("pready", {31'h0, pready}, 32'h1);
    rd("stat", `ESR_A_STAT, 32'h0, skip_ninth);
    rd("baud", `ESR_A_BAUD, 32'h0);
    rd("irq stat", `ESR_A_IRQ_STAT, 32'h0);
    rd("irq mask", `ESR_A_IRQ_MASK, 32'h0);
    rd("unmapped", 8'h20, 32'h0, 32'hffffffff, 1'b1);
    // continuous master reception, three characters into two places
    wr(`ESR_A_BAUD, 32'h0103);
    wr(`ESR_A_IRQ_MASK, 32'h1);
    wr(`ESR_A_CTRL, 32'h07);
    check("oe_n", {31'h0, clk_pin_oe_n}, 32'h0);
    load(3, 1'b0);
    i_tx.edges = 0;
    wr(`ESR_A_CTRL, 32'h17);
    @(posedge clk_pin_o);
    t0 = $time;
    @(posedge clk_pin_o);
    check("clock period", 32'(($time - t0) / 100), 32'd8);
    wait_chars(3, 8, 4);
    check("clock edges", 32'(i_tx.edges), 32'd24);
    check("irq", {31'h0, irq}, 32'h1);
    rd("irq stat", `ESR_A_IRQ_STAT, 32'h3);
    rd("stat", `ESR_A_STAT, 32'h6, skip_ninth);
    rd("data 0", `ESR_A_DATA, {24'h0, c[0][7:0]});
    rd("stat", `ESR_A_STAT, 32'h6, skip_ninth);
    rd("data 1", `ESR_A_DATA, {24'h0, c[1][7:0]});
    rd("stat", `ESR_A_STAT, 32'h2, skip_ninth);
    wr(`ESR_A_STAT, 32'h0);
    rd("stat", `ESR_A_STAT, 32'h2, skip_ninth);
    wr(`ESR_A_CTRL, 32'h07);
    rd("stat", `ESR_A_STAT, 32'h0, skip_ninth);
    wr(`ESR_A_IRQ_STAT, 32'h3);
    check("irq", {31'h0, irq}, 32'h0);
    // overrun again, cleared by turning the port off
    load(3, 1'b0);
    wr(`ESR_A_CTRL, 32'h17);
    wait_chars(3, 8, 4);
    rd("stat", `ESR_A_STAT, 32'h6, skip_ninth);
    wr(`ESR_A_CTRL, 32'h16);
    rd("stat", `ESR_A_STAT, 32'h0, skip_ninth);
    wr(`ESR_A_CTRL, 32'h0);
    wr(`ESR_A_IRQ_MASK, 32'h0);
    wr(`ESR_A_IRQ_STAT, 32'h3);
    // nine-bit single receptions, 16-bit divisor, late transmitter
    i_tx.slow = 1'b1;
    i_tx.nine = 1'b1;
    load(3, 1'b1);
    wr(`ESR_A_CTRL, 32'h67);
    for (int i = 0; i < 3; i++)
    begin
      wr(`ESR_A_CTRL, 32'h6f);
      wait_chars(1, 9, 260);
    end
    rd("ctrl", `ESR_A_CTRL, 32'h67);
    check("irq", {31'h0, irq}, 32'h0);
    rd("irq stat", `ESR_A_IRQ_STAT, 32'h3);
    wr(`ESR_A_IRQ_MASK, 32'h2);
    check("irq", {31'h0, irq}, 32'h1);
    rd("stat", `ESR_A_STAT, {29'h0, 2'b11, c[0][8]});
    rd("data 0", `ESR_A_DATA, {24'h0, c[0][7:0]});
    rd("stat", `ESR_A_STAT, {29'h0, 2'b10, c[1][8]});
    rd("data 1", `ESR_A_DATA, {24'h0, c[1][7:0]});
    rd("stat", `ESR_A_STAT, 32'h0, skip_ninth);
    wr(`ESR_A_CTRL, 32'h0);
    i_tx.slow = 1'b0;
    i_tx.nine = 1'b0;
    // slave clocking by the transmitter's own 800 ns clock
    load(1, 1'b0);
    wr(`ESR_A_CTRL, 32'h13);
    check("oe_n", {31'h0, clk_pin_oe_n}, 32'h1);
    i_tx.run_clock(8);
    repeat (10) @(posedge clk);
    rd("stat", `ESR_A_STAT, 32'h4, skip_ninth);
    rd("data 0", `ESR_A_DATA, {24'h0, c[0][7:0]});
    wr(`ESR_A_CTRL, 32'h0);
    tally_and_finish();
  end

  // watchdog, about twice the expected run
  initial
  begin
    #3000000;
    errors++;
    tally_and_finish();
  end
endmodule
